// File: verilog/abeu_defs.svh
// Purpose: Constants for the arithmetic and branch execution unit
// Assumes: 16-bit instruction words, 32 working registers
// Notes: Status flag positions follow the usual 8-bit core layout
// Behaviour
// (RULE1) Add and add-with-carry write sum, set Z C N V H, one cycle.
// (RULE2) Word add/sub immediate act on register pair, set Z C N V S, two cycles.
// (RULE3) Subtract forms write difference, set Z C N V H, one cycle.
// (RULE4) AND, OR, XOR forms set only Z N V, one cycle; the code also updates S.
// (RULE5) Test ANDs register with itself, value kept, sets Z N V.
// (RULE6) Multiplies put 16-bit product in r1:r0, set Z C, two cycles.
// (RULE7) Fractional multiplies shift product left one, set Z C, two cycles.
// (RULE8) Indirect jump loads PC from Z, no flags, two cycles.
// (RULE9) Indirect call loads PC from Z, pushes return, three cycles.
// (RULE10) Compare-skip skips next when equal, one to three cycles.
// (RULE11) Register-bit skips test a bit clear or set, one to three cycles.
// (RULE12) I/O-bit skips test an I/O bit level, one to three cycles.
// (RULE13) Compares subtract without storing, set Z N V C H, one cycle.
// (RULE14) Flag branches add offset plus one when bit matches, one or two cycles.
// (RULE15) Signed branches use N xor V equal zero or one.
// (RULE16) Unsigned branches use carry clear or set.
// (RULE17) Half-carry branches use H set or clear.
// (RULE18) Overflow branch taken when V set.
// (RULE19) Transfer-bit branches use T, one cycle untaken, two taken.
// (RULE20) H is carry or borrow from bit 3; S equals N xor V.
`ifndef ABEU_DEFS_SVH
`define ABEU_DEFS_SVH
`define ABEU_FLAG_C 0
`define ABEU_FLAG_Z 1
`define ABEU_FLAG_N 2
`define ABEU_FLAG_V 3
`define ABEU_FLAG_S 4
`define ABEU_FLAG_H 5
`define ABEU_FLAG_T 6
`define ABEU_FLAG_I 7
`define ABEU_SP_RESET 16'h10ff
`define ABEU_PC_RESET 16'h0000
`define ABEU_REG_Z_LO 30
`define ABEU_REG_Z_HI 31
`endif

// File: verilog/abeu_pkg.sv
// Purpose: Types for the execution unit
// Assumes: abeu_defs.svh constants
// Notes: Operation codes are internal decode results
package abeu_pkg;
   typedef enum logic [5:0] {
      ABEU_OP_NOP, ABEU_OP_ADD, ABEU_OP_ADC, ABEU_OP_WORD_ADD_IMM, ABEU_OP_WORD_SUB_IMM,
      ABEU_OP_SUB, ABEU_OP_SUB_IMM, ABEU_OP_SUB_REGS_BORROW, ABEU_OP_SUB_IMM_BORROW,
      ABEU_OP_AND, ABEU_OP_AND_IMM, ABEU_OP_OR, ABEU_OP_OR_IMM, ABEU_OP_XOR_REGS,
      ABEU_OP_MULT_UNSIGNED, ABEU_OP_MULT_SIGNED, ABEU_OP_MULT_SIGNED_UNSIGNED,
      ABEU_OP_FRAC_MULT_UNSIGNED, ABEU_OP_FRAC_MULT_SIGNED, ABEU_OP_FRAC_MULT_MIXED,
      ABEU_OP_INDIRECT_JUMP, ABEU_OP_INDIRECT_CALL, ABEU_OP_COMPARE_SKIP_EQUAL,
      ABEU_OP_COMPARE_REGS, ABEU_OP_COMPARE_REGS_CARRY, ABEU_OP_COMPARE_IMM,
      ABEU_OP_SKIP_REG_BIT_CLEAR, ABEU_OP_SKIP_REG_BIT_SET, ABEU_OP_SKIP_IO_BIT_CLEAR,
      ABEU_OP_SKIP_IO_BIT_SET, ABEU_OP_BRANCH_FLAG_SET, ABEU_OP_BRANCH_FLAG_CLEAR
   } abeu_op_type;

   typedef struct packed {
      abeu_op_type op;
      logic [4:0]  rd;
      logic [4:0]  rr;
      logic [7:0]  imm;
      logic [2:0]  bitsel;
      logic [5:0]  io_addr;
      logic [6:0]  offset;
      logic        is_word;
   } abeu_dec_type;

   typedef struct packed {
      logic [7:0] res;
      logic [7:0] res_hi;
      logic [7:0] flags;
      logic       wr_rd;
      logic       wr_pair;
      logic       wr_prod;
   } abeu_alu_type;

   typedef enum {
      ABEU_ST_FETCH, ABEU_ST_EXEC2, ABEU_ST_EXEC3, ABEU_ST_SKIP
   } abeu_state_type;

   typedef struct packed {
      abeu_state_type st;
      logic [15:0]    pc;
      logic [15:0]    sp;
      logic [7:0]     flags;
      logic [255:0]   regs;
      abeu_alu_type   pend;
      abeu_dec_type   dec;
      logic [15:0]    push_val;
      logic           push_lo;
      logic           retire;
      logic [7:0]     dmem_wdata;
      logic [15:0]    dmem_addr;
      logic           dmem_we;
   } abeu_core_type;
endpackage

// File: verilog/abeu_decode.sv
// Purpose: Instruction word decode
// Assumes: 16-bit opcode words, combinational
// Notes: Unknown words decode as no operation
module abeu_decode
   import abeu_pkg::*;
(
   input  wire logic [15:0]          i_word,
   output abeu_pkg::abeu_dec_type    o_dec
);
   always_comb
   begin
      o_dec         = '0;
      o_dec.op      = ABEU_OP_NOP;
      o_dec.rd      = i_word[8:4];
      o_dec.rr      = {i_word[9], i_word[3:0]};
      o_dec.imm     = {i_word[11:8], i_word[3:0]};
      o_dec.bitsel  = i_word[2:0];
      o_dec.io_addr = {1'b0, i_word[7:3]};
      o_dec.offset  = i_word[9:3];
      casez (i_word)
         16'b0000_11??_????_????: o_dec.op = ABEU_OP_ADD;
         16'b0001_11??_????_????: o_dec.op = ABEU_OP_ADC;
         16'b0001_10??_????_????: o_dec.op = ABEU_OP_SUB;
         16'b0000_10??_????_????: o_dec.op = ABEU_OP_SUB_REGS_BORROW;
         16'b0010_00??_????_????: o_dec.op = ABEU_OP_AND;
         16'b0010_10??_????_????: o_dec.op = ABEU_OP_OR;
         16'b0010_01??_????_????: o_dec.op = ABEU_OP_XOR_REGS;
         16'b0001_01??_????_????: o_dec.op = ABEU_OP_COMPARE_REGS;
         16'b0000_01??_????_????: o_dec.op = ABEU_OP_COMPARE_REGS_CARRY;
         16'b0001_00??_????_????: o_dec.op = ABEU_OP_COMPARE_SKIP_EQUAL;
         16'b1001_11??_????_????: o_dec.op = ABEU_OP_MULT_UNSIGNED;
         default:
         begin
            o_dec.op = ABEU_OP_NOP;
         end
      endcase
      casez (i_word)
         16'b0011_????_????_????: o_dec.op = ABEU_OP_COMPARE_IMM;
         16'b0101_????_????_????: o_dec.op = ABEU_OP_SUB_IMM;
         16'b0100_????_????_????: o_dec.op = ABEU_OP_SUB_IMM_BORROW;
         16'b0111_????_????_????: o_dec.op = ABEU_OP_AND_IMM;
         16'b0110_????_????_????: o_dec.op = ABEU_OP_OR_IMM;
         default:
         begin
            o_dec.op = o_dec.op;
         end
      endcase
      if (i_word[15:12] >= 4'h3 && i_word[15:12] <= 4'h7)
      begin
         o_dec.rd = {1'b1, i_word[7:4]};
      end
      casez (i_word)
         16'b1001_0110_????_????:
         begin
            o_dec.op      = ABEU_OP_WORD_ADD_IMM;
            o_dec.is_word = 1'b1;
         end
         16'b1001_0111_????_????:
         begin
            o_dec.op      = ABEU_OP_WORD_SUB_IMM;
            o_dec.is_word = 1'b1;
         end
         16'b0000_0010_????_????: o_dec.op = ABEU_OP_MULT_SIGNED;
         16'b0000_0011_0???_0???: o_dec.op = ABEU_OP_MULT_SIGNED_UNSIGNED;
         16'b0000_0011_0???_1???: o_dec.op = ABEU_OP_FRAC_MULT_UNSIGNED;
         16'b0000_0011_1???_0???: o_dec.op = ABEU_OP_FRAC_MULT_SIGNED;
         16'b0000_0011_1???_1???: o_dec.op = ABEU_OP_FRAC_MULT_MIXED;
         16'b1001_0100_0000_1001: o_dec.op = ABEU_OP_INDIRECT_JUMP;
         16'b1001_0101_0000_1001: o_dec.op = ABEU_OP_INDIRECT_CALL;
         16'b1111_110?_????_0???: o_dec.op = ABEU_OP_SKIP_REG_BIT_CLEAR;
         16'b1111_111?_????_0???: o_dec.op = ABEU_OP_SKIP_REG_BIT_SET;
         16'b1001_1001_????_????: o_dec.op = ABEU_OP_SKIP_IO_BIT_CLEAR;
         16'b1001_1011_????_????: o_dec.op = ABEU_OP_SKIP_IO_BIT_SET;
         16'b1111_00??_????_????: o_dec.op = ABEU_OP_BRANCH_FLAG_SET;
         16'b1111_01??_????_????: o_dec.op = ABEU_OP_BRANCH_FLAG_CLEAR;
         default:
         begin
            o_dec.op = o_dec.op;
         end
      endcase
      if (o_dec.is_word)
      begin
         o_dec.rd  = {2'b11, i_word[5:4], 1'b0};
         o_dec.imm = {2'b00, i_word[7:6], i_word[3:0]};
      end
      if (i_word[15:8] == 8'h02)
      begin
         o_dec.rd = {1'b1, i_word[7:4]};
         o_dec.rr = {1'b1, i_word[3:0]};
      end
      if (i_word[15:8] == 8'h03)
      begin
         o_dec.rd = {2'b10, i_word[6:4]};
         o_dec.rr = {2'b10, i_word[2:0]};
      end
   end
endmodule

// File: verilog/abeu_alu.sv
// Purpose: Arithmetic, logic and multiply datapath
// Assumes: Operands fetched by the caller
// Notes: Flags not named by an operation pass through unchanged, except S, which is always recomputed as N xor V
`include "abeu_defs.svh"
module abeu_alu
   import abeu_pkg::*;
(
   input  wire abeu_pkg::abeu_dec_type i_dec,
   input  wire logic [7:0]             i_a,
   input  wire logic [7:0]             i_b,
   input  wire logic [7:0]             i_a_hi,
   input  wire logic [7:0]             i_flags,
   output abeu_pkg::abeu_alu_type      o_alu
);
   logic [8:0]  sum;
   logic [4:0]  nib;
   logic [7:0]  opb;
   logic        cin;
   logic        sub;
   logic        keepz;
   logic [16:0] wsum;
   logic [15:0] prod;
   logic [17:0] sprod;
   logic        sa;
   logic        sb;
   always_comb
   begin
      o_alu = '0;
      o_alu.flags = i_flags;
      sub = 1'b0;
      cin = 1'b0;
      keepz = 1'b0;
      opb = i_b;
      case (i_dec.op)
         ABEU_OP_ADC: cin = i_flags[`ABEU_FLAG_C];
         ABEU_OP_SUB, ABEU_OP_SUB_IMM, ABEU_OP_COMPARE_REGS, ABEU_OP_COMPARE_IMM: sub = 1'b1;
         ABEU_OP_SUB_REGS_BORROW, ABEU_OP_SUB_IMM_BORROW, ABEU_OP_COMPARE_REGS_CARRY:
         begin
            sub = 1'b1;
            keepz = 1'b1;
            cin = i_flags[`ABEU_FLAG_C];
         end
         default:
         begin
            sub = 1'b0;
         end
      endcase
      if (sub)
      begin
         sum = {1'b0, i_a} - {1'b0, opb} - {8'h00, cin};
         nib = {1'b0, i_a[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
      end
      else
      begin
         sum = {1'b0, i_a} + {1'b0, opb} + {8'h00, cin};
         nib = {1'b0, i_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      end
      wsum = i_dec.op == ABEU_OP_WORD_SUB_IMM ? {1'b0, i_a_hi, i_a} - {9'h000, i_b}
                                              : {1'b0, i_a_hi, i_a} + {9'h000, i_b};
      sa = i_dec.op inside {ABEU_OP_MULT_SIGNED, ABEU_OP_MULT_SIGNED_UNSIGNED,
                            ABEU_OP_FRAC_MULT_SIGNED, ABEU_OP_FRAC_MULT_MIXED};
      sb = i_dec.op inside {ABEU_OP_MULT_SIGNED, ABEU_OP_FRAC_MULT_SIGNED};
      sprod = 18'($signed({sa & i_a[7], i_a}) * $signed({sb & i_b[7], i_b}));
      prod = sprod[15:0];
      case (i_dec.op)
         ABEU_OP_ADD, ABEU_OP_ADC, ABEU_OP_SUB, ABEU_OP_SUB_IMM, ABEU_OP_SUB_REGS_BORROW,
         ABEU_OP_SUB_IMM_BORROW, ABEU_OP_COMPARE_REGS, ABEU_OP_COMPARE_REGS_CARRY,
         ABEU_OP_COMPARE_IMM:
         begin
            o_alu.res = sum[7:0];
            o_alu.wr_rd = !(i_dec.op inside {ABEU_OP_COMPARE_REGS, ABEU_OP_COMPARE_REGS_CARRY,
                                           ABEU_OP_COMPARE_IMM}); // RULE13
            o_alu.flags[`ABEU_FLAG_C] = sum[8]; // RULE1 RULE3 RULE13
            o_alu.flags[`ABEU_FLAG_H] = nib[4]; // RULE20
            o_alu.flags[`ABEU_FLAG_N] = sum[7];
            o_alu.flags[`ABEU_FLAG_V] = sub ? (i_a[7] ^ opb[7]) & (i_a[7] ^ sum[7])
                                            : ~(i_a[7] ^ opb[7]) & (i_a[7] ^ sum[7]);
            o_alu.flags[`ABEU_FLAG_Z] = (sum[7:0] == 8'h00) &
                                        (!keepz | i_flags[`ABEU_FLAG_Z]);
         end
         ABEU_OP_WORD_ADD_IMM, ABEU_OP_WORD_SUB_IMM:
         begin
            o_alu.res = wsum[7:0]; // RULE2
            o_alu.res_hi = wsum[15:8];
            o_alu.wr_pair = 1'b1;
            o_alu.flags[`ABEU_FLAG_C] = wsum[16];
            o_alu.flags[`ABEU_FLAG_N] = wsum[15];
            o_alu.flags[`ABEU_FLAG_V] = (i_dec.op == ABEU_OP_WORD_ADD_IMM) ?
                                        ~i_a_hi[7] & wsum[15] : i_a_hi[7] & ~wsum[15];
            o_alu.flags[`ABEU_FLAG_Z] = wsum[15:0] == 16'h0000;
         end
         ABEU_OP_AND, ABEU_OP_AND_IMM, ABEU_OP_OR, ABEU_OP_OR_IMM, ABEU_OP_XOR_REGS:
         begin
            o_alu.res = (i_dec.op inside {ABEU_OP_AND, ABEU_OP_AND_IMM}) ? i_a & i_b :
                        (i_dec.op == ABEU_OP_XOR_REGS) ? i_a ^ i_b : i_a | i_b; // RULE4 RULE5
            o_alu.wr_rd = 1'b1;
            o_alu.flags[`ABEU_FLAG_N] = o_alu.res[7];
            o_alu.flags[`ABEU_FLAG_V] = 1'b0;
            o_alu.flags[`ABEU_FLAG_Z] = o_alu.res == 8'h00;
         end
         ABEU_OP_MULT_UNSIGNED, ABEU_OP_MULT_SIGNED, ABEU_OP_MULT_SIGNED_UNSIGNED,
         ABEU_OP_FRAC_MULT_UNSIGNED, ABEU_OP_FRAC_MULT_SIGNED, ABEU_OP_FRAC_MULT_MIXED:
         begin
            o_alu.flags[`ABEU_FLAG_C] = prod[15]; // RULE6 RULE7
            if (i_dec.op inside {ABEU_OP_FRAC_MULT_UNSIGNED, ABEU_OP_FRAC_MULT_SIGNED,
                                 ABEU_OP_FRAC_MULT_MIXED})
            begin
               prod = {prod[14:0], 1'b0}; // RULE7
            end
            {o_alu.res_hi, o_alu.res} = prod; // RULE6
            o_alu.wr_prod = 1'b1;
            o_alu.flags[`ABEU_FLAG_Z] = prod == 16'h0000;
         end
         default:
         begin
            o_alu.res = 8'h00;
         end
      endcase
      o_alu.flags[`ABEU_FLAG_S] = o_alu.flags[`ABEU_FLAG_N] ^ o_alu.flags[`ABEU_FLAG_V]; // RULE20
   end
endmodule

// File: verilog/abeu_core.sv
// Purpose: Execution unit for arithmetic, multiply, jump, skip and branch groups
// Assumes: Program memory answers combinationally at o_pc; I/O bits arrive on a port
// Notes: Other instruction groups execute as one-cycle no operations
`include "abeu_defs.svh"
module abeu_core
   import abeu_pkg::*;
(
   input  wire logic            i_sys_clk,
   input  wire logic            i_rstn,
   input  wire logic [15:0]     i_instr,
   input  wire logic [15:0]     i_next_instr,
   input  wire logic [63:0]     i_io_bits,
   output logic [15:0]          o_pc,
   output logic [7:0]           o_status_flags_reg,
   output logic [15:0]          o_sp,
   output logic                 o_retire,
   output logic                 o_dmem_we,
   output logic [15:0]          o_dmem_addr,
   output logic [7:0]           o_dmem_wdata,
   output logic [255:0]         o_regs
);
   abeu_core_type r_r;
   abeu_core_type r_nxt;
   abeu_dec_type  dec;
   abeu_alu_type  alu;
   logic [7:0]    ra;
   logic [7:0]    rb;
   logic [7:0]    ra_hi;
   logic [7:0]    b_in;
   logic          skip_cond;
   logic          br_cond;
   logic          next_long;
   logic [15:0]   zptr;
   logic [2:0]    flag_sel;

   abeu_decode u_dec
   (
      .i_word (i_instr),
      .o_dec  (dec)
   );

   assign ra    = r_r.regs[dec.rd*8 +: 8];
   assign rb    = r_r.regs[dec.rr*8 +: 8];
   assign ra_hi = r_r.regs[(dec.rd+5'd1)*8 +: 8];
   assign zptr  = {r_r.regs[`ABEU_REG_Z_HI*8 +: 8], r_r.regs[`ABEU_REG_Z_LO*8 +: 8]};
   assign b_in  = (dec.op inside {ABEU_OP_SUB_IMM, ABEU_OP_SUB_IMM_BORROW, ABEU_OP_AND_IMM,
                  ABEU_OP_OR_IMM, ABEU_OP_COMPARE_IMM, ABEU_OP_WORD_ADD_IMM,
                  ABEU_OP_WORD_SUB_IMM}) ? dec.imm : rb;
   assign flag_sel = dec.bitsel;
   assign next_long = (i_next_instr[15:10] == 6'b100101) &
                      (i_next_instr[3:1] == 3'b110 || i_next_instr[3:1] == 3'b111) |
                      (i_next_instr[15:10] == 6'b100100) & (i_next_instr[3:0] == 4'h0);

   abeu_alu u_alu
   (
      .i_dec   (dec),
      .i_a     (ra),
      .i_b     (b_in),
      .i_a_hi  (ra_hi),
      .i_flags (r_r.flags),
      .o_alu   (alu)
   );

   always_comb
   begin
      skip_cond = 1'b0;
      br_cond = 1'b0;
      case (dec.op)
         ABEU_OP_COMPARE_SKIP_EQUAL: skip_cond = ra == rb; // RULE10
         ABEU_OP_SKIP_REG_BIT_CLEAR: skip_cond = !ra[flag_sel]; // RULE11
         ABEU_OP_SKIP_REG_BIT_SET:   skip_cond = ra[flag_sel]; // RULE11
         ABEU_OP_SKIP_IO_BIT_CLEAR:  skip_cond = !i_io_bits[{dec.io_addr[2:0], flag_sel}]; // RULE12
         ABEU_OP_SKIP_IO_BIT_SET:    skip_cond = i_io_bits[{dec.io_addr[2:0], flag_sel}]; // RULE12
         ABEU_OP_BRANCH_FLAG_SET:    br_cond = r_r.flags[flag_sel]; // RULE14 RULE15 RULE17 RULE18 RULE19
         ABEU_OP_BRANCH_FLAG_CLEAR:  br_cond = !r_r.flags[flag_sel]; // RULE14 RULE15 RULE16 RULE19
         default:
         begin
            skip_cond = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      r_nxt = r_r;
      r_nxt.retire = 1'b0;
      r_nxt.dmem_we = 1'b0;
      case (r_r.st)
         ABEU_ST_FETCH:
         begin
            r_nxt.dec = dec;
            r_nxt.pend = alu;
            r_nxt.pc = r_r.pc + 16'h0001;
            r_nxt.retire = 1'b1;
            if (dec.op inside {ABEU_OP_WORD_ADD_IMM, ABEU_OP_WORD_SUB_IMM, ABEU_OP_MULT_UNSIGNED,
                ABEU_OP_MULT_SIGNED, ABEU_OP_MULT_SIGNED_UNSIGNED, ABEU_OP_FRAC_MULT_UNSIGNED,
                ABEU_OP_FRAC_MULT_SIGNED, ABEU_OP_FRAC_MULT_MIXED})
            begin
               r_nxt.retire = 1'b0; // RULE2 RULE6 RULE7
               r_nxt.st = ABEU_ST_EXEC2;
            end
            else if (dec.op inside {ABEU_OP_INDIRECT_JUMP, ABEU_OP_INDIRECT_CALL})
            begin
               r_nxt.retire = 1'b0;
               r_nxt.pc = zptr; // RULE8 RULE9
               r_nxt.push_val = r_r.pc + 16'h0001;
               r_nxt.st = ABEU_ST_EXEC2;
            end
            else if (skip_cond)
            begin
               r_nxt.retire = 1'b0;
               r_nxt.pc = r_r.pc + (next_long ? 16'h0003 : 16'h0002); // RULE10 RULE11 RULE12
               r_nxt.st = next_long ? ABEU_ST_EXEC3 : ABEU_ST_EXEC2;
            end
            else if (br_cond)
            begin
               r_nxt.retire = 1'b0;
               r_nxt.pc = r_r.pc + {{9{dec.offset[6]}}, dec.offset} + 16'h0001; // RULE14
               r_nxt.st = ABEU_ST_EXEC2;
            end
            else
            begin
               r_nxt.flags = alu.flags; // RULE1 RULE3 RULE4 RULE5 RULE13
               if (alu.wr_rd)
               begin
                  r_nxt.regs[dec.rd*8 +: 8] = alu.res;
               end
            end
         end
         ABEU_ST_EXEC2:
         begin
            r_nxt.st = ABEU_ST_FETCH;
            r_nxt.retire = 1'b1;
            r_nxt.flags = r_r.pend.flags;
            if (r_r.pend.wr_pair)
            begin
               r_nxt.regs[r_r.dec.rd*8 +: 16] = {r_r.pend.res_hi, r_r.pend.res}; // RULE2
            end
            if (r_r.pend.wr_prod)
            begin
               r_nxt.regs[15:0] = {r_r.pend.res_hi, r_r.pend.res}; // RULE6 RULE7
            end
            if (r_r.dec.op == ABEU_OP_INDIRECT_CALL)
            begin
               r_nxt.retire = 1'b0; // RULE9
               r_nxt.st = ABEU_ST_EXEC3;
               r_nxt.dmem_we = 1'b1;
               r_nxt.dmem_addr = r_r.sp;
               r_nxt.dmem_wdata = r_r.push_val[7:0];
               r_nxt.sp = r_r.sp - 16'h0001;
            end
         end
         ABEU_ST_EXEC3:
         begin
            r_nxt.st = ABEU_ST_FETCH;
            r_nxt.retire = 1'b1;
            if (r_r.dec.op == ABEU_OP_INDIRECT_CALL)
            begin
               r_nxt.dmem_we = 1'b1; // RULE9
               r_nxt.dmem_addr = r_r.sp;
               r_nxt.dmem_wdata = r_r.push_val[15:8];
               r_nxt.sp = r_r.sp - 16'h0001;
            end
            else
            begin
               r_nxt.st = ABEU_ST_SKIP;
               r_nxt.retire = 1'b0;
            end
         end
         default:
         begin
            r_nxt.st = ABEU_ST_FETCH;
            r_nxt.retire = 1'b1;
         end
      endcase
      if (r_r.st != ABEU_ST_FETCH)
      begin
         r_nxt.flags = r_nxt.flags;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         r_r <= '0;
         r_r.st <= ABEU_ST_FETCH;
         r_r.sp <= `ABEU_SP_RESET;
         r_r.pc <= `ABEU_PC_RESET;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign o_pc = r_r.pc;
   assign o_status_flags_reg = r_r.flags;
   assign o_sp = r_r.sp;
   assign o_retire = r_r.retire;
   assign o_dmem_we = r_r.dmem_we;
   assign o_dmem_addr = r_r.dmem_addr;
   assign o_dmem_wdata = r_r.dmem_wdata;
   assign o_regs = r_r.regs;

   chk_jump_two_cycles: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && dec.op == ABEU_OP_INDIRECT_JUMP |=> o_pc == $past(zptr)
      ##1 o_retire) else $error("indirect jump timing wrong"); // RULE8
   chk_call_three_cyc: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && dec.op == ABEU_OP_INDIRECT_CALL |=> !o_retire ##1
      o_dmem_we ##1 o_dmem_we && o_retire) else $error("indirect call timing wrong"); // RULE9
   chk_mult_two_cyc: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && alu.wr_prod |=> !o_retire ##1
      o_regs[15:0] == {$past(alu.res_hi, 2), $past(alu.res, 2)})
      else $error("multiply result wrong"); // RULE6
   chk_add_flags_now: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && dec.op == ABEU_OP_ADD && !br_cond |=>
      o_status_flags_reg == $past(alu.flags) && o_retire) else $error("add flags wrong"); // RULE1
   chk_sign_flag_xor: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      $changed(o_status_flags_reg) && $past(r_r.st) == ABEU_ST_FETCH && $past(dec.op) != ABEU_OP_NOP
      |-> o_status_flags_reg[`ABEU_FLAG_S] ==
      (o_status_flags_reg[`ABEU_FLAG_N] ^ o_status_flags_reg[`ABEU_FLAG_V]))
      else $error("sign flag mismatch"); // RULE20
   chk_branch_target: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && br_cond |=>
      o_pc == $past(r_r.pc) + {{9{$past(dec.offset[6])}}, $past(dec.offset)} + 16'h0001
      ##1 o_retire) else $error("branch target wrong"); // RULE14
   chk_skip_advance: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && skip_cond |=>
      (o_pc == $past(r_r.pc) + 16'h0002) || (o_pc == $past(r_r.pc) + 16'h0003))
      else $error("skip advance wrong"); // RULE10
   chk_compare_nostore: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && dec.op == ABEU_OP_COMPARE_REGS |=>
      o_regs == $past(r_r.regs)) else $error("compare stored result"); // RULE13
   chk_logic_keeps_c: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r_r.st == ABEU_ST_FETCH && dec.op == ABEU_OP_AND |=>
      o_status_flags_reg[`ABEU_FLAG_C] == $past(r_r.flags[`ABEU_FLAG_C]))
      else $error("logic op changed carry"); // RULE4
endmodule

// File: verif/abeu_prog_mem.sv
// Purpose: Program memory model feeding instruction words to the core
// Assumes: Combinational read at the program counter
// Notes: Unset words read as no operation; the word index wraps every 16 words
module abeu_prog_mem (
   input  wire logic [15:0] i_pc,
   output logic [15:0]      o_word,
   output logic [15:0]      o_next_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:15];
   initial
   begin
      foreach (mem[i]) mem[i] = 16'h0000;
      mem[0] = 16'h5001;
      mem[1] = 16'h0f00;
      mem[2] = 16'h9f00;
      mem[3] = 16'hf010;
      mem[6] = 16'h1300;
      mem[8] = 16'h1701;
      mem[9] = 16'h9601;
      mem[10] = 16'h963c;
      mem[11] = 16'h9509;
      mem[12] = 16'h2300;
      mem[13] = 16'h9b00;
      mem[15] = 16'h9409;
   end
   assign o_word      = mem[i_pc[3:0]];
   assign o_next_word = mem[i_pc[3:0] + 4'h1];
endmodule

// File: verif/arith_branch_exec_unit_tb.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: Fixed program in the memory model
// Notes: Each step waits for retire and checks cycles, pc, flags
module arith_branch_exec_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import abeu_pkg::*;
   logic         i_sys_clk, i_rstn;
   logic [15:0]  instr, next_instr, pc, sp, we_addr;
   logic [7:0]   flags, wdata, lo_push;
   logic [255:0] regs;
   logic         retire, we;
   logic [63:0]  io_bits;
   int           mismatches, total_checks;
   abeu_core i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_instr(instr),
      .i_next_instr(next_instr), .i_io_bits(io_bits), .o_pc(pc),
      .o_status_flags_reg(flags), .o_sp(sp), .o_retire(retire), .o_dmem_we(we),
      .o_dmem_addr(we_addr), .o_dmem_wdata(wdata), .o_regs(regs));
   abeu_prog_mem i_rom (.i_pc(pc), .o_word(instr), .o_next_word(next_instr));
   // Capture of the first stack push, mid-cycle
   always @(negedge i_sys_clk)
      if (we === 1'b1 && we_addr == 16'h10ff) lo_push <= wdata;
   initial
   begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input logic [15:0] pc_e, input int cyc_e, input logic [7:0] fl_e);
      int n;
      n = 0;
      do
      begin
         @(posedge i_sys_clk);
         #1 n++;
      end while (retire !== 1'b1 && n < 8);
      check(n, cyc_e);
      check(pc, pc_e);
      check(flags, fl_e);
   endtask
   task automatic t_arith;
      step(16'h0001, 1, 8'h35);
      check(regs[135:128], 8'hff);
      step(16'h0002, 1, 8'h35);
      check(regs[135:128], 8'hfe);
   endtask
   task automatic t_mult;
      step(16'h0003, 2, 8'h35);
      check(regs[15:0], 16'hfc04);
   endtask
   task automatic t_branch;
      step(16'h0006, 2, 8'h35);
   endtask
   task automatic t_skip;
      step(16'h0008, 2, 8'h35);
   endtask
   task automatic t_cmp;
      step(16'h0009, 1, 8'h14);
      check(regs[135:128], 8'hfe);
   endtask
   task automatic t_word;
      step(16'h000a, 2, 8'h00);
      check(regs[207:192], 16'h0001);
   endtask
   task automatic t_call;
      step(16'h000b, 2, 8'h00);
      check(regs[255:240], 16'h000c);
      step(16'h000c, 3, 8'h00);
      check({we, we_addr, wdata}, {1'b1, 16'h10fe, 8'h00});
      check(sp, 16'h10fd);
      check(lo_push, 8'h0c);
   endtask
   task automatic t_jump;
      step(16'h000d, 1, 8'h14);
      check(regs[135:128], 8'hfe);
      step(16'h000f, 2, 8'h14);
      step(16'h000c, 2, 8'h14);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #2000;
      mismatches++;
      results();
   end
   initial
   begin
      mismatches = 0;
      total_checks = 0;
      i_rstn = 1'b0;
      io_bits = 64'h1;
      repeat (3) @(posedge i_sys_clk);
      #1 check(sp, 32'h10ff);
      check(pc, 32'h0);
      @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      t_arith();
      t_mult();
      t_branch();
      t_skip();
      t_cmp();
      t_word();
      t_call();
      t_jump();
      results();
   end
endmodule
